/* slcfg_pkg.sv */
// Functional notes
// - lane seven id: five bits, resets to 7
// - bit 7 enables scrambler, resets on
// - lane count codes 0,1,3,7; reset eight
// - octets per frame is field plus one, kept to five bits
// - frames per multiframe field plus one, 0x1F
// - converter count zero means one converter
// - codes 1,3,7 mean two, four, eight
package slcfg_pkg;
    // byte addresses are four times the printed register index
    localparam logic [11:0] IDX_LANE7  = 12'h58A;
    localparam logic [11:0] IDX_SCR_L  = 12'h58B;
    localparam logic [11:0] IDX_F      = 12'h58C;
    localparam logic [11:0] IDX_K      = 12'h58D;
    localparam logic [11:0] IDX_M      = 12'h58E;
    localparam int          ADDR_W     = 14;
    localparam logic [7:0]  RST_LANE7  = 8'h07;
    localparam logic [7:0]  RST_SCR_L  = 8'h87;
    localparam logic [7:0]  RST_F      = 8'h00;
    localparam logic [7:0]  RST_K      = 8'h1F;
    localparam logic [7:0]  RST_M      = 8'h01;
    localparam logic [7:0]  MASK_LANE7 = 8'h1F;
    localparam logic [7:0]  MASK_SCR_L = 8'h9F;
    localparam logic [7:0]  MASK_F     = 8'hFF;
    localparam logic [7:0]  MASK_K     = 8'h1F;
    localparam logic [7:0]  MASK_M     = 8'hFF;
    localparam int          SCR_BIT    = 7;
    localparam int          NREG       = 5;

    typedef logic [7:0] slcfg_byte_t;

    // map a printed index to its aligned byte address
    function automatic logic [ADDR_W-1:0] slcfg_addr(input logic [11:0] idx);
        return {idx, 2'b00};
    endfunction
endpackage

/* slcfg_wr_if.sv */
`timescale 1ns/100ps
`default_nettype none
// write request from the bus slave to the register store
interface slcfg_wr_if;
    logic                     we;
    logic [2:0]               sel;
    slcfg_pkg::slcfg_byte_t   data;
    modport master (output we, sel, data);
    modport store  (input we, sel, data);
endinterface
`default_nettype wire

/* slcfg_store.sv */
`timescale 1ns/100ps
`default_nettype none
module slcfg_store (
    // clock and reset
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    // write port
    slcfg_wr_if.store                          wr,
    // register contents
    output var slcfg_pkg::slcfg_byte_t         regs [slcfg_pkg::NREG]
);
    localparam slcfg_pkg::slcfg_byte_t RSTV [slcfg_pkg::NREG] = '{
        slcfg_pkg::RST_LANE7, slcfg_pkg::RST_SCR_L, slcfg_pkg::RST_F,
        slcfg_pkg::RST_K, slcfg_pkg::RST_M};
    localparam slcfg_pkg::slcfg_byte_t MSKV [slcfg_pkg::NREG] = '{
        slcfg_pkg::MASK_LANE7, slcfg_pkg::MASK_SCR_L, slcfg_pkg::MASK_F,
        slcfg_pkg::MASK_K, slcfg_pkg::MASK_M};

    // masked write keeps reserved bits at zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < slcfg_pkg::NREG; i++) begin
                regs[i] <= RSTV[i];
            end
        end else if (wr.we && (int'(wr.sel) < slcfg_pkg::NREG)) begin
            regs[wr.sel] <= wr.data & MSKV[wr.sel];
        end
    end
endmodule // slcfg_store
`default_nettype wire

/* slcfg_regs.sv */
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module slcfg_regs (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // link configuration
    output logic      [4:0]  lane7_id,
    output logic             scr_en,
    output logic      [3:0]  lanes,
    output logic      [4:0]  octets_per_frame,
    output logic      [5:0]  frames_per_multiframe,
    output logic      [3:0]  converters
);
    slcfg_wr_if             wr ();
    slcfg_pkg::slcfg_byte_t regs [slcfg_pkg::NREG];
    logic                   ph_wr;
    logic [2:0]             ph_sel;
    logic                   ph_hit;
    logic [2:0]             a_sel;
    logic                   a_hit;
    logic                   fwd_hit;
    localparam slcfg_pkg::slcfg_byte_t RD_MSK [slcfg_pkg::NREG] = '{
        slcfg_pkg::MASK_LANE7, slcfg_pkg::MASK_SCR_L, slcfg_pkg::MASK_F,
        slcfg_pkg::MASK_K, slcfg_pkg::MASK_M};

    // decode: register index from word address
    always_comb begin
        a_sel = 3'h0;
        a_hit = 1'b0;
        for (int i = 0; i < slcfg_pkg::NREG; i++) begin
            if (haddr[slcfg_pkg::ADDR_W-1:0] ==
                slcfg_pkg::slcfg_addr(slcfg_pkg::IDX_LANE7 + 12'(i))
                && haddr[31:slcfg_pkg::ADDR_W] == '0) begin
                a_sel = 3'(i);
                a_hit = 1'b1;
            end
        end
    end

    // address phase capture; zero wait states, so always ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr  <= 1'b0;
            ph_sel <= 3'h0;
            ph_hit <= 1'b0;
        end else if (hready) begin
            ph_wr  <= hsel && htrans[1] && hwrite;
            ph_sel <= a_sel;
            ph_hit <= a_hit;
        end
    end

    assign wr.we   = ph_wr && ph_hit;
    assign wr.sel  = ph_sel;
    assign wr.data = hwdata[7:0];
    // a read pipelined behind a write to the same register sees the new byte
    assign fwd_hit = wr.we && (wr.sel == a_sel);

    slcfg_store u_store (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr      (wr),
        .regs    (regs)
    );

    // read data registered; unmapped reads return zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= a_hit ? {24'h0, fwd_hit ? (wr.data & RD_MSK[a_sel]) : regs[a_sel]}
                            : 32'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // decoded link parameters, one cycle behind the store
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lane7_id              <= 5'h07;
            scr_en                <= 1'b1;
            lanes                 <= 4'h8;
            octets_per_frame      <= 5'h01;
            frames_per_multiframe <= 6'h20;
            converters            <= 4'h2;
        end else begin
            lane7_id              <= regs[0][4:0];
            scr_en                <= regs[1][slcfg_pkg::SCR_BIT];
            lanes                 <= 4'(regs[1][4:0]) + 4'h1;
            octets_per_frame      <= 5'(regs[2]) + 5'h01;
            frames_per_multiframe <= 6'(regs[3][4:0]) + 6'h01;
            converters            <= 4'(regs[4]) + 4'h1;
        end
    end

    a_scr_reset: assert property (@(posedge hclk)
        $rose(hresetn) |-> scr_en) else $error("scrambler not on after reset");
    a_lane_reset: assert property (@(posedge hclk)
        $rose(hresetn) |-> lanes == 4'h8) else $error("lanes not eight");
    a_oct_calc: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 octets_per_frame == 5'($past(regs[2])) + 5'h01) else $error("F wrong");
    a_k_calc: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 frames_per_multiframe == 6'($past(regs[3][4:0])) + 6'h01)
        else $error("K wrong");
    a_conv_calc: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 converters == 4'($past(regs[4])) + 4'h1) else $error("M wrong");
    a_res_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        regs[0][7:5] == 3'h0 && regs[1][6:5] == 2'h0 && regs[3][7:5] == 3'h0)
        else $error("reserved set");
    a_lid_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr.we && wr.sel == 3'h0 |=> ##1 lane7_id == $past(wr.data[4:0], 2))
        else $error("lane id not written");
    a_lane_code: assert property (@(posedge hclk) disable iff (!hresetn)
        regs[1][4:0] == 5'h3 |=> lanes == 4'h4) else $error("L code");
    a_m_code: assert property (@(posedge hclk) disable iff (!hresetn)
        regs[4] == 8'h07 |=> converters == 4'h8) else $error("M code");
    c_write: cover property (@(posedge hclk) wr.we);
    c_scr_off: cover property (@(posedge hclk) !scr_en);
    c_read: cover property (@(posedge hclk) hsel && htrans[1] && !hwrite && a_hit);
endmodule // slcfg_regs
`default_nettype wire

/* tb_serial_link_param_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_serial_link_param_config_regs;
    localparam logic [11:0] IDX [5] = '{12'h58A, 12'h58B, 12'h58C, 12'h58D, 12'h58E};
    localparam logic [7:0]  RV [5]  = '{8'h07, 8'h87, 8'h00, 8'h1F, 8'h01};
    localparam logic [7:0]  MK [5]  = '{8'h1F, 8'h9F, 8'hFF, 8'h1F, 8'hFF};
    localparam logic [7:0]  FC [7]  = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0F};
    localparam logic [4:0]  LC [4]  = '{5'h00, 5'h01, 5'h03, 5'h07};
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, x;
    logic [31:0] seed = 32'h00013267;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, scr_en;
    logic [4:0]  lane7_id, octets_per_frame;
    logic [5:0]  frames_per_multiframe;
    logic [3:0]  lanes, converters;
    logic [7:0]  m [5];
    logic [7:0]  v;
    int          bad_count = 0, checks_done = 0, cyc = 0, k;
    wire logic   hready = hreadyout;
    slcfg_regs DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .lane7_id, .scr_en, .lanes, .octets_per_frame,
        .frames_per_multiframe, .converters);
    // 20 MHz bus clock
    always #25 hclk = ~hclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // decoded link settings as the model registers imply them
    function automatic logic [26:0] exp_out();
        return {2'b01, m[0][4:0], m[1][7], m[1][3:0] + 4'h1, m[2][4:0] + 5'h01,
            {1'b0, m[3][4:0]} + 6'h01, m[4][3:0] + 4'h1};
    endfunction
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // outputs settle one edge after the store, so look just past the edge
    task automatic chk_out();
        #1;
        chk({5'h0, hresp, hreadyout, lane7_id, scr_en, lanes, octets_per_frame,
            frames_per_multiframe, converters}, {5'h0, exp_out()});
    endtask
    // one single ahb-lite transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [11:0] i, input logic [31:0] d);
        int n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {18'h0, i, 2'h0};
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 99);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 99);
        rd = hrdata;
        if (w && i >= 12'h58A && i <= 12'h58E) m[i - 12'h58A] = d[7:0] & MK[i - 12'h58A];
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge hclk) begin
        if (++cyc == 3000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        m = RV;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        for (k = 0; k < 5; k++) begin
            bus(1'b0, IDX[k], 32'h0);
            chk(rd, {24'h0, RV[k]});
        end
        chk_out();
        for (k = 0; k < 5; k++) begin
            bus(1'b1, IDX[k], 32'hFFFFFFFF);
            bus(1'b0, IDX[k], 32'h0);
            chk(rd, {24'h0, m[k]});
        end
        bus(1'b1, 12'h58F, 32'hFFFFFFFF);
        bus(1'b0, 12'h58F, 32'h0);
        chk(rd, 32'h0);
        // random legal settings, back to back with their read back
        repeat (60) begin
            x = rnd();
            k = x[31:8] % 5;
            case (k)
                0: v = x[7:0];
                1: v = {x[7:5], LC[x[9:8]]};
                2: v = FC[x[10:8] % 7];
                3: v = {x[7:2], 2'b11};
                default: v = {3'h0, LC[x[1:0]]};
            endcase
            bus(1'b1, IDX[k], {x[31:8], v});
            bus(1'b0, IDX[k], 32'h0);
            chk(rd, {24'h0, m[k]});
            chk_out();
        end
        // second reset at the end of the run restores every default
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        m = RV;
        chk_out();
        complete_run();
    end
endmodule // tb_serial_link_param_config_regs
`default_nettype wire
